// [hw/tag_eeprom_regs.svh]
`ifndef TAG_EEPROM_REGS_SVH
`define TAG_EEPROM_REGS_SVH
`define WORD_UID 5'h00
`define WORD_FAB 5'h01
`define WORD_CFG 5'h02
`define WORD_WLOCK 5'h03
`define WORD_RLOCK 5'h04
`define WORD_USER_FIRST 5'h05
`define LOCK_FREEZE_BIT 2
`define CFG_DEFAULT 32'h26000000
// identity words: arbitrary values, they name no real maker or part
`define UID_VALUE 32'h5A3C0F01
`define FAB_VALUE 32'h00000001
`define CFG_FSCI 31:28
`define CFG_FWI 27:24
`define CFG_RATE 23:17
`define CFG_NOT_LEVEL4 16
`define CFG_NFC 15
`define CFG_PU_IRQ_EN 14
`define CFG_IRQ_ACT 13
`define CFG_MODE 12:11
`define CFG_RXNCRC 10
`define CFG_RXBS 9
`define CFG_TXNCRC 8
`define CFG_TXBS 7
`define CFG_FDEL 6:5
`define CFG_VREG 4:3
`define CFG_RREG 2:1
`define MODE_L4 2'h0
`define MODE_L3 2'h1
`define MODE_FRAME 2'h2
`define MODE_TRANSP 2'h3
`define FDEL_00 4'h6
`define FDEL_01 4'h4
`define FDEL_10 4'h2
`define FDEL_11 4'h8
`define ST_OK 2'h0
`define ST_LOCKED 2'h1
`define ST_DENIED 2'h2
`define CLK_MHZ 40
`define PROG_TIME_US 8000
`endif

// [hw/tag_eeprom_pkg.sv]
package tag_eeprom_pkg;
    typedef enum logic [1:0] {S_INIT, S_IDLE, S_PROG, S_GAP} state_e;
    typedef logic [1:0] status_t;
    typedef logic [4:0] word_addr_t;
endpackage

// [hw/nv_word_array.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tag_eeprom_regs.svh"
module nv_word_array #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o,
    output logic [WIDTH-1:0] wlock_o,
    output logic [WIDTH-1:0] rlock_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // factory image: identity words, default options, blank elsewhere
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = '0;
        end
        mem[`WORD_UID] = `UID_VALUE; // arbitrary identity value
        mem[`WORD_FAB] = `FAB_VALUE; // arbitrary identity value
        mem[`WORD_CFG] = `CFG_DEFAULT;
    end

    // single write port, nonvolatile so no reset
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // asynchronous reads of the addressed word and both lock words
    assign rdata_o = mem[raddr_i];
    assign wlock_o = mem[`WORD_WLOCK];
    assign rlock_o = mem[`WORD_RLOCK];
endmodule
`default_nettype wire

// [hw/tag_eeprom_access.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tag_eeprom_regs.svh"
module tag_eeprom_access #(
    parameter int unsigned PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic rf_req_i,
    input wire logic rf_we_i,
    input wire logic [4:0] rf_addr_i,
    input wire logic [31:0] rf_wdata_i,
    output logic rf_done_o,
    output logic [1:0] rf_status_o,
    output logic [31:0] rf_rdata_o,
    input wire logic sp_req_i,
    input wire logic sp_we_i,
    input wire logic [4:0] sp_addr_i,
    input wire logic [31:0] sp_wdata_i,
    output logic sp_done_o,
    output logic [1:0] sp_status_o,
    output logic [31:0] sp_rdata_o,
    input wire logic sak_sent_i,
    input wire logic host_irq_i,
    input wire logic spi_miso_i,
    input wire logic spi_miso_en_i,
    input wire logic mod_ctl_i,
    input wire logic ss_n_pin_i,
    input wire logic mosi_pin_i,
    input wire logic clk_extr_pin_i,
    input wire logic demod_pin_i,
    input wire logic field_on_pin_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    output logic modulator_o,
    output logic irq_o,
    output logic init_done_o,
    output logic [3:0] frame_size_idx_o,
    output logic [3:0] wait_time_idx_o,
    output logic [6:0] rate_caps_o,
    output logic not_level4_flag_o,
    output logic nfc_target_o,
    output logic [1:0] op_mode_o,
    output logic rx_no_crc_o,
    output logic rx_raw_o,
    output logic tx_no_crc_o,
    output logic tx_raw_o,
    output logic [3:0] fdel_cycles_o,
    output logic [1:0] vreg_sel_o,
    output logic [1:0] rreg_sel_o
);
    localparam int CW = $clog2(PROG_CYCLES + 1);
    localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

    // pin synchronisers: ss_n, mosi, clock extractor, demodulator, field
    logic [4:0] pin_raw, pin_s1_r, pin_s2_r;
    assign pin_raw = {field_on_pin_i, demod_pin_i, clk_extr_pin_i, mosi_pin_i, ss_n_pin_i};
    generate
        for (genvar g = 0; g < 5; g++) begin : g_sync
            always_ff @(posedge mclk_i) begin
                pin_s1_r[g] <= pin_raw[g];
                pin_s2_r[g] <= pin_s1_r[g];
            end
        end
    endgenerate
    logic ss_s, mosi_s, clkx_s, demod_s, field_s;
    assign {field_s, demod_s, clkx_s, mosi_s, ss_s} = pin_s2_r;

    tag_eeprom_pkg::state_e state_r, state_nxt;
    logic own_rf_r, own_rf_nxt;
    logic [4:0] addr_r, addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [31:0] cfg_r, cfg_nxt;
    logic rf_done_r, rf_done_nxt, sp_done_r, sp_done_nxt;
    logic [1:0] rf_status_r, rf_status_nxt, sp_status_r, sp_status_nxt;
    logic [31:0] rf_rdata_r, rf_rdata_nxt, sp_rdata_r, sp_rdata_nxt;
    logic init_done_r, init_done_nxt, evt_irq;
    logic mem_we;
    logic [4:0] raddr;
    logic [31:0] rd_data, wlock, rlock;

    nv_word_array #(.WIDTH(32), .DEPTH(32), .AW(5)) u_array (
        .mclk_i(mclk_i),
        .we_i(mem_we),
        .waddr_i(addr_r),
        .wdata_i(wdata_r),
        .raddr_i(raddr),
        .rdata_o(rd_data),
        .wlock_o(wlock),
        .rlock_o(rlock)
    );

    // request selection; contactless side wins a tie
    logic rf_take, sp_take, bypass, sp_denied, take_we, wr_refused, lock_word, rd_hidden;
    logic [4:0] take_addr;
    logic [31:0] take_wdata;
    logic [1:0] mode;
    assign mode = cfg_r[`CFG_MODE];
    assign bypass = (mode == `MODE_TRANSP) && ss_s;
    assign sp_denied = ((mode == `MODE_L4) && field_s) || bypass;
    assign rf_take = (state_r == tag_eeprom_pkg::S_IDLE) && rf_req_i;
    assign sp_take = (state_r == tag_eeprom_pkg::S_IDLE) && sp_req_i && !rf_req_i;
    assign take_addr = rf_take ? rf_addr_i : sp_addr_i;
    assign take_we = rf_take ? rf_we_i : sp_we_i;
    assign take_wdata = rf_take ? rf_wdata_i : sp_wdata_i;
    assign lock_word = (take_addr == `WORD_WLOCK) || (take_addr == `WORD_RLOCK);
    // refuse identity words, locked words and frozen lock words
    assign wr_refused = (take_addr <= `WORD_FAB)
                     || wlock[take_addr]
                     || (lock_word && wlock[`LOCK_FREEZE_BIT]);
    assign rd_hidden = (take_addr >= `WORD_USER_FIRST) && rlock[take_addr];
    assign raddr = (state_r == tag_eeprom_pkg::S_INIT) ? `WORD_CFG :
                   (state_r == tag_eeprom_pkg::S_IDLE) ? take_addr : addr_r;
    assign mem_we = (state_r == tag_eeprom_pkg::S_PROG) && (cnt_r == '0);

    // access sequencer: init load, read answer, write programming
    always_comb begin
        state_nxt = state_r;
        own_rf_nxt = own_rf_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        cnt_nxt = cnt_r;
        cfg_nxt = cfg_r;
        init_done_nxt = init_done_r;
        rf_done_nxt = 1'b0;
        sp_done_nxt = 1'b0;
        rf_status_nxt = rf_status_r;
        sp_status_nxt = sp_status_r;
        rf_rdata_nxt = rf_rdata_r;
        sp_rdata_nxt = sp_rdata_r;
        evt_irq = 1'b0;
        case (state_r)
            tag_eeprom_pkg::S_INIT: begin
                cfg_nxt = rd_data;
                init_done_nxt = 1'b1;
                evt_irq = rd_data[`CFG_PU_IRQ_EN];
                state_nxt = tag_eeprom_pkg::S_IDLE;
            end
            tag_eeprom_pkg::S_IDLE: begin
                if (rf_take) begin
                    own_rf_nxt = 1'b1;
                    addr_nxt = take_addr;
                    if (take_we && wr_refused) begin
                        rf_done_nxt = 1'b1;
                        rf_status_nxt = `ST_LOCKED;
                        state_nxt = tag_eeprom_pkg::S_GAP;
                    end else if (take_we) begin
                        // lock words merge new ones into old ones
                        wdata_nxt = lock_word ? (rd_data | take_wdata) : take_wdata;
                        cnt_nxt = PROG_LAST;
                        state_nxt = tag_eeprom_pkg::S_PROG;
                    end else begin
                        rf_done_nxt = 1'b1;
                        rf_status_nxt = rd_hidden ? `ST_LOCKED : `ST_OK;
                        rf_rdata_nxt = rd_hidden ? 32'h00000000 : rd_data;
                        state_nxt = tag_eeprom_pkg::S_GAP;
                    end
                end else if (sp_take) begin
                    own_rf_nxt = 1'b0;
                    addr_nxt = take_addr;
                    if (sp_denied || (take_we && wr_refused)) begin
                        sp_done_nxt = 1'b1;
                        sp_status_nxt = sp_denied ? `ST_DENIED : `ST_LOCKED;
                        state_nxt = tag_eeprom_pkg::S_GAP;
                    end else if (take_we) begin
                        wdata_nxt = lock_word ? (rd_data | take_wdata) : take_wdata;
                        cnt_nxt = PROG_LAST;
                        state_nxt = tag_eeprom_pkg::S_PROG;
                    end else begin
                        sp_done_nxt = 1'b1;
                        sp_status_nxt = `ST_OK;
                        sp_rdata_nxt = rd_data;
                        state_nxt = tag_eeprom_pkg::S_GAP;
                    end
                end
            end
            tag_eeprom_pkg::S_PROG: begin
                if (cnt_r == '0) begin
                    rf_done_nxt = own_rf_r;
                    sp_done_nxt = !own_rf_r;
                    if (own_rf_r) begin
                        rf_status_nxt = `ST_OK;
                    end else begin
                        sp_status_nxt = `ST_OK;
                    end
                    state_nxt = tag_eeprom_pkg::S_GAP;
                end else begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            default: begin
                state_nxt = tag_eeprom_pkg::S_IDLE;
            end
        endcase
        if (sak_sent_i && cfg_r[`CFG_IRQ_ACT] && (mode == `MODE_L4 || mode == `MODE_L3)) begin
            evt_irq = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_r <= tag_eeprom_pkg::S_INIT;
            own_rf_r <= 1'b0;
            addr_r <= 5'h00;
            wdata_r <= 32'h00000000;
            cnt_r <= '0;
            cfg_r <= `CFG_DEFAULT;
            init_done_r <= 1'b0;
            rf_done_r <= 1'b0;
            sp_done_r <= 1'b0;
            rf_status_r <= `ST_OK;
            sp_status_r <= `ST_OK;
            rf_rdata_r <= 32'h00000000;
            sp_rdata_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            own_rf_r <= own_rf_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            cnt_r <= cnt_nxt;
            cfg_r <= cfg_nxt;
            init_done_r <= init_done_nxt;
            rf_done_r <= rf_done_nxt;
            sp_done_r <= sp_done_nxt;
            rf_status_r <= rf_status_nxt;
            sp_status_r <= sp_status_nxt;
            rf_rdata_r <= rf_rdata_nxt;
            sp_rdata_r <= sp_rdata_nxt;
        end
    end

    // pin mux and decoded options
    logic miso_r, miso_nxt, oe_n_r, oe_n_nxt, mod_r, mod_nxt, irq_r, irq_nxt;
    logic nfc_r, nfc_nxt;
    logic [3:0] fdel_r, fdel_nxt;
    always_comb begin
        miso_nxt = bypass ? clkx_s : spi_miso_i;
        oe_n_nxt = bypass ? 1'b0 : !spi_miso_en_i;
        mod_nxt = bypass ? mosi_s : mod_ctl_i;
        irq_nxt = bypass ? demod_s : (host_irq_i || evt_irq);
        nfc_nxt = cfg_r[`CFG_NFC] && !cfg_r[`CFG_NOT_LEVEL4];
        case (cfg_r[`CFG_FDEL])
            2'h0: fdel_nxt = `FDEL_00;
            2'h1: fdel_nxt = `FDEL_01;
            2'h2: fdel_nxt = `FDEL_10;
            default: fdel_nxt = `FDEL_11;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            miso_r <= 1'b0;
            oe_n_r <= 1'b1;
            mod_r <= 1'b0;
            irq_r <= 1'b0;
            nfc_r <= 1'b0;
            fdel_r <= `FDEL_00;
        end else begin
            miso_r <= miso_nxt;
            oe_n_r <= oe_n_nxt;
            mod_r <= mod_nxt;
            irq_r <= irq_nxt;
            nfc_r <= nfc_nxt;
            fdel_r <= fdel_nxt;
        end
    end

    // outputs straight from registers; option fields are slices of cfg_r, except nfc_r and fdel_r, registered decodes of it
    assign rf_done_o = rf_done_r;
    assign rf_status_o = rf_status_r;
    assign rf_rdata_o = rf_rdata_r;
    assign sp_done_o = sp_done_r;
    assign sp_status_o = sp_status_r;
    assign sp_rdata_o = sp_rdata_r;
    assign miso_o = miso_r;
    assign miso_oe_n_o = oe_n_r;
    assign modulator_o = mod_r;
    assign irq_o = irq_r;
    assign init_done_o = init_done_r;
    assign frame_size_idx_o = cfg_r[`CFG_FSCI];
    assign wait_time_idx_o = cfg_r[`CFG_FWI];
    assign rate_caps_o = cfg_r[`CFG_RATE];
    assign not_level4_flag_o = cfg_r[`CFG_NOT_LEVEL4];
    assign nfc_target_o = nfc_r;
    assign op_mode_o = mode;
    assign rx_no_crc_o = cfg_r[`CFG_RXNCRC];
    assign rx_raw_o = cfg_r[`CFG_RXBS];
    assign tx_no_crc_o = cfg_r[`CFG_TXNCRC];
    assign tx_raw_o = cfg_r[`CFG_TXBS];
    assign fdel_cycles_o = fdel_r;
    assign vreg_sel_o = cfg_r[`CFG_VREG];
    assign rreg_sel_o = cfg_r[`CFG_RREG];

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    chk_ro_words: assert property ((rf_take && rf_we_i && rf_addr_i <= `WORD_FAB)
        |=> rf_done_o && rf_status_o == `ST_LOCKED) else $error("identity word written");
    chk_otp_keep: assert property ((mem_we
        && (addr_r == `WORD_WLOCK || addr_r == `WORD_RLOCK))
        |-> ((wdata_r & rd_data) == rd_data)) else $error("lock bit cleared");
    chk_wlock_block: assert property ((sp_take && sp_we_i && !sp_denied && wlock[sp_addr_i])
        |=> sp_done_o && sp_status_o == `ST_LOCKED) else $error("locked word written");
    chk_lock_freeze: assert property ((rf_take && rf_we_i && wlock[`LOCK_FREEZE_BIT]
        && rf_addr_i == `WORD_RLOCK) |=> rf_status_o == `ST_LOCKED)
        else $error("frozen lock written");
    chk_rlock_hide: assert property ((rf_take && !rf_we_i && rd_hidden)
        |=> rf_rdata_o == 32'h00000000 ##1 state_r == tag_eeprom_pkg::S_IDLE)
        else $error("hidden word leaked");
    chk_rlock_low: assert property ((rf_take && !rf_we_i && rf_addr_i < `WORD_USER_FIRST)
        |=> rf_status_o == `ST_OK && rf_rdata_o == $past(rd_data)) else $error("low word hidden");
    chk_init_first: assert property (!init_done_o |-> !rf_done_o && !sp_done_o)
        else $error("answer before init");
    chk_pu_irq: assert property ((state_r == tag_eeprom_pkg::S_INIT
        && rd_data[`CFG_PU_IRQ_EN] && !bypass) |=> irq_o) else $error("power-up irq missing");
    chk_bypass_mod: assert property (bypass && $stable(bypass)
        |=> modulator_o == $past(mosi_s) && miso_o == $past(clkx_s) && !miso_oe_n_o)
        else $error("bypass pins wrong");
    chk_fdel_map: assert property (cfg_r[`CFG_FDEL] == 2'h3 |=> fdel_cycles_o == `FDEL_11)
        else $error("delay map wrong");
    cov_rf_write: cover property (rf_take && rf_we_i && !wr_refused ##[1:1000] rf_done_o);
    cov_rf_hidden: cover property (rf_take && !rf_we_i && rd_hidden);
    cov_sp_denied: cover property (sp_take && sp_denied);
    cov_bypass: cover property (bypass ##1 modulator_o);
endmodule
`default_nettype wire

// [test/tag_afe_model.sv]
`timescale 1ns/1ps
`default_nettype none
// analogue front end stand-in feeding the tag pins
module tag_afe_model (
    input wire logic mclk_i,
    input wire logic field_en_i,
    input wire logic modulator_i,
    output logic clk_extr_o,
    output logic demod_o,
    output logic field_on_o
);
    // both pins rest low with no field; extracted clock toggles only under field
    // demodulator echoes load modulation
    always @(posedge mclk_i) begin
        clk_extr_o <= field_en_i ? ~clk_extr_o : 1'b0;
        demod_o <= field_en_i & modulator_i;
    end
    assign field_on_o = field_en_i;
endmodule
`default_nettype wire

// [test/tag_eeprom_config_lock_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tag_eeprom_regs.svh"
module tag_eeprom_config_lock_tb;
    typedef struct packed {logic sp; logic chk_d; logic [1:0] st; logic [31:0] d;} exp_s;
    logic mclk_i = 1'b0;
    logic rstn_i, rf_req_i, rf_we_i, sp_req_i, sp_we_i, sak_sent_i, host_irq_i, spi_miso_i;
    logic spi_miso_en_i, mod_ctl_i, ss_n_pin_i, mosi_pin_i, field_en;
    logic clk_extr_pin_i, demod_pin_i, field_on_pin_i;
    logic [4:0] rf_addr_i, sp_addr_i;
    logic [31:0] rf_wdata_i, sp_wdata_i, rf_rdata_o, sp_rdata_o, c, w5;
    logic [1:0] rf_status_o, sp_status_o, op_mode_o, vreg_sel_o, rreg_sel_o;
    logic rf_done_o, sp_done_o, miso_o, miso_oe_n_o, modulator_o, irq_o, init_done_o;
    logic not_level4_flag_o, nfc_target_o, rx_no_crc_o, rx_raw_o, tx_no_crc_o, tx_raw_o;
    logic [3:0] frame_size_idx_o, wait_time_idx_o, fdel_cycles_o;
    logic [6:0] rate_caps_o;
    int errors = 0;
    int n_compared = 0;
    exp_s exp_q[$];
    exp_s e;

    tag_eeprom_access #(.PROG_CYCLES(6)) dut (.mclk_i, .rstn_i, .rf_req_i, .rf_we_i, .rf_addr_i,
        .rf_wdata_i, .rf_done_o, .rf_status_o, .rf_rdata_o, .sp_req_i, .sp_we_i, .sp_addr_i,
        .sp_wdata_i, .sp_done_o, .sp_status_o, .sp_rdata_o, .sak_sent_i, .host_irq_i,
        .spi_miso_i, .spi_miso_en_i, .mod_ctl_i, .ss_n_pin_i, .mosi_pin_i, .clk_extr_pin_i,
        .demod_pin_i, .field_on_pin_i, .miso_o, .miso_oe_n_o, .modulator_o, .irq_o,
        .init_done_o, .frame_size_idx_o, .wait_time_idx_o, .rate_caps_o, .not_level4_flag_o,
        .nfc_target_o, .op_mode_o, .rx_no_crc_o, .rx_raw_o, .tx_no_crc_o, .tx_raw_o,
        .fdel_cycles_o, .vreg_sel_o, .rreg_sel_o);

    tag_afe_model afe (.mclk_i, .field_en_i(field_en), .modulator_i(modulator_o),
        .clk_extr_o(clk_extr_pin_i), .demod_o(demod_pin_i), .field_on_o(field_on_pin_i));

    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [3:0] fdel_exp(input logic [1:0] f);
        return f == 2'h0 ? 4'h6 : f == 2'h1 ? 4'h4 : f == 2'h2 ? 4'h2 : 4'h8;
    endfunction

    // one word access on either side; the answer is noted for the watcher
    task automatic acc(input logic s, input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [1:0] st, input logic [31:0] ed);
        int n;
        exp_q.push_back('{s, !w && st != `ST_DENIED, st, ed});
        @(posedge mclk_i) #2;
        if (s) {sp_req_i, sp_we_i, sp_addr_i, sp_wdata_i} = {1'b1, w, a, d};
        else {rf_req_i, rf_we_i, rf_addr_i, rf_wdata_i} = {1'b1, w, a, d};
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while ((s ? sp_done_o : rf_done_o) !== 1'b1 && n < 100);
        check(32'(n < 100), 32'h1, "answer arrived");
        @(posedge mclk_i) #2;
        rf_req_i = 1'b0;
        sp_req_i = 1'b0;
    endtask

    // every answer pulse takes the oldest note off the queue
    always @(negedge mclk_i) begin
        if (rf_done_o === 1'b1 || sp_done_o === 1'b1) begin
            check(32'(exp_q.size() > 0), 32'h1, "answer expected");
            e = exp_q.pop_front();
            check(32'(e.sp ? sp_status_o : rf_status_o), 32'(e.st), "status");
            if (e.chk_d) check(e.sp ? sp_rdata_o : rf_rdata_o, e.d, "read data");
        end
    end

    // reset, then live options must match the stored word
    task automatic do_reset(input logic [31:0] cw);
        int n;
        logic [31:0] v;
        @(posedge mclk_i) #2;
        rstn_i = 1'b0;
        repeat (5) @(posedge mclk_i);
        #2 rstn_i = 1'b1;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (init_done_o !== 1'b1 && n < 10);
        check(32'(init_done_o), 32'h1, "init done");
        check(32'(irq_o), 32'(cw[14]), "power-up interrupt");
        // registered decodes follow the loaded word one cycle later
        @(negedge mclk_i);
        check(32'(irq_o), 32'h0, "power-up pulse ends");
        v = 32'({frame_size_idx_o, wait_time_idx_o, rate_caps_o, not_level4_flag_o, nfc_target_o});
        check(v, 32'({cw[31:16], cw[15] & ~cw[16]}), "select options");
        v = 32'({op_mode_o, rx_no_crc_o, rx_raw_o, tx_no_crc_o, tx_raw_o, vreg_sel_o, rreg_sel_o});
        check(v, 32'({cw[12:7], cw[4:1]}), "operating options");
        check(32'(fdel_cycles_o), 32'(fdel_exp(cw[6:5])), "delay compensation");
    endtask

    task automatic sak_check(input logic exp);
        @(posedge mclk_i) #2;
        sak_sent_i = 1'b1;
        @(posedge mclk_i) #2;
        sak_sent_i = 1'b0;
        @(negedge mclk_i);
        check(32'(irq_o), 32'(exp), "active entry interrupt");
        @(negedge mclk_i);
        check(32'(irq_o), 32'h0, "active entry pulse ends");
    endtask

    // serial engine pins pass straight through outside bypass
    task automatic pins_normal();
        @(posedge mclk_i) #2;
        {spi_miso_i, spi_miso_en_i, mod_ctl_i, host_irq_i} = 4'($urandom);
        repeat (2) @(negedge mclk_i);
        check(32'({miso_o, miso_oe_n_o, modulator_o, irq_o}),
              32'({spi_miso_i, ~spi_miso_en_i, mod_ctl_i, host_irq_i}), "normal pins");
        @(posedge mclk_i) #2;
        host_irq_i = 1'b0;
    endtask

    initial begin
        #200000;
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        {rstn_i, rf_req_i, rf_we_i, sp_req_i, sp_we_i, sak_sent_i, host_irq_i} = '0;
        {spi_miso_i, spi_miso_en_i, mod_ctl_i, ss_n_pin_i, mosi_pin_i, field_en} = '0;
        {rf_addr_i, sp_addr_i, rf_wdata_i, sp_wdata_i} = '0;
        void'($urandom(32'h353B09B3));
        do_reset(`CFG_DEFAULT);
        acc(1'b0, 1'b0, `WORD_UID, 32'h0, `ST_OK, `UID_VALUE);
        acc(1'b1, 1'b0, `WORD_FAB, 32'h0, `ST_OK, `FAB_VALUE);
        acc(1'b0, 1'b0, `WORD_CFG, 32'h0, `ST_OK, `CFG_DEFAULT);
        for (int i = 0; i < 4; i++) acc(i[0], 1'b1, 5'(i[1]), $urandom, `ST_LOCKED, 0);
        for (int i = 0; i < 6; i++) begin
            c[4:0] = 5'($urandom_range(31, 5));
            w5 = $urandom;
            acc(i[0], 1'b1, c[4:0], w5, `ST_OK, 32'h0);
            acc(~i[0], 1'b0, c[4:0], 32'h0, `ST_OK, w5);
        end
        $display("test read only and user words done");
        for (int i = 0; i < 4; i++) begin
            c = $urandom;
            c[12:11] = 2'(i);
            c[6:5] = 2'(i);
            c[16:14] = {i[0], 1'b1, i[1]};
            acc(1'b1, 1'b1, `WORD_CFG, c, `ST_OK, 32'h0);
            do_reset(c);
            sak_check(c[13] && i < 2);
            pins_normal();
            field_en = 1'b1;
            ss_n_pin_i = 1'b1;
            mosi_pin_i = 1'b1;
            repeat (10) @(negedge mclk_i);
            if (i == 3) begin
                check(32'({modulator_o, irq_o, miso_oe_n_o, miso_o}),
                      32'({2'b11, 1'b0, ~clk_extr_pin_i}), "bypass pins");
                acc(1'b1, 1'b0, `WORD_CFG, 32'h0, `ST_DENIED, 32'h0);
            end
            @(posedge mclk_i) #2;
            ss_n_pin_i = 1'b0;
            repeat (4) @(posedge mclk_i);
            acc(1'b1, 1'b0, `WORD_CFG, 32'h0, i == 0 ? `ST_DENIED : `ST_OK, c);
            field_en = 1'b0;
            repeat (4) @(posedge mclk_i);
        end
        acc(1'b1, 1'b1, `WORD_CFG, `CFG_DEFAULT, `ST_OK, 32'h0);
        do_reset(`CFG_DEFAULT);
        $display("test configuration decode and pins done");
        w5 = $urandom;
        acc(1'b0, 1'b1, 5'h05, w5, `ST_OK, 32'h0);
        acc(1'b0, 1'b1, `WORD_WLOCK, 32'h21, `ST_OK, 32'h0);
        acc(1'b0, 1'b1, 5'h05, $urandom, `ST_LOCKED, 32'h0);
        acc(1'b1, 1'b1, 5'h05, $urandom, `ST_LOCKED, 32'h0);
        acc(1'b1, 1'b1, 5'h06, $urandom, `ST_OK, 32'h0);
        acc(1'b1, 1'b1, `WORD_UID, $urandom, `ST_LOCKED, 32'h0);
        acc(1'b1, 1'b1, `WORD_WLOCK, 32'h0, `ST_OK, 32'h0);
        acc(1'b1, 1'b0, `WORD_WLOCK, 32'h0, `ST_OK, 32'h21);
        acc(1'b0, 1'b1, `WORD_RLOCK, 32'h28, `ST_OK, 32'h0);
        acc(1'b0, 1'b0, 5'h05, 32'h0, `ST_LOCKED, 32'h0);
        acc(1'b1, 1'b0, 5'h05, 32'h0, `ST_OK, w5);
        acc(1'b0, 1'b0, `WORD_WLOCK, 32'h0, `ST_OK, 32'h21);
        $display("test lock words done");
        acc(1'b0, 1'b1, `WORD_WLOCK, 32'h04, `ST_OK, 32'h0);
        acc(1'b0, 1'b1, `WORD_RLOCK, 32'h40, `ST_LOCKED, 32'h0);
        acc(1'b1, 1'b1, `WORD_WLOCK, 32'h100, `ST_LOCKED, 32'h0);
        acc(1'b1, 1'b0, `WORD_RLOCK, 32'h0, `ST_OK, 32'h28);
        acc(1'b1, 1'b0, `WORD_WLOCK, 32'h0, `ST_OK, 32'h25);
        $display("test lock freeze done");
        final_report();
    end
endmodule
`default_nettype wire
